// *** inc/csp_pkg.sv ***
// Notes on behaviour
// - External clock modes start at once, no oscillator start-up wait after reset or sleep.
// - External clock modes drive the secondary pin with the input clock divided by four.
// - Multiplier runs only with its enable bit set and a multiplier-capable mode chosen.
// - Multiplier takes a 4 MHz reference and yields 96 MHz for core and USB.
// - Eight-ratio input prescaler brings 4 MHz multiples down to the 4 MHz reference.
// - Core divider derives the core clock from the multiplier path by 1, 2, 3 or 6.
// - Main internal oscillator gives 8 MHz directly and through a postscaler down to 31 kHz.
// - Internal multiplier modes feed the 8 MHz oscillator into the multiplier, up to 48 MHz.
// - Slow oscillator runs when selected or when any of four timer features is enabled.
// - Frequency-select field picks main direct, slow direct or a postscaler output.
// - Trim write settles quickly; execution continues and no completion flag exists.
// - Each trim step changes the main oscillator rate by the same amount.
// - Bit 7 picks main divided by 256 or the slow oscillator for 31 kHz.
// - Modes without multiplier keep it off whatever the enable bit says.
// - Enabling the multiplier switches the core only after the full 2 ms lock count and a seen reference.
// - Six-bit trim is two's complement: zero centre, 011111 max, 100000 min.
// - USB clock is 6 MHz for low speed or 48 MHz for full speed.
// - Multiplier output is divided to feed USB and core at the same time.
// - Core divider ratio comes from a configuration field: 1, 2, 3 or 6.
// - Low-speed USB needs a 24 MHz core so USB gets 6 MHz.
package csp_pkg;

  // Timing
  localparam int CLK_FREQ_KHZ    = 100000;
  localparam int LOCK_TIME_US    = 2000;
  localparam int LOCK_CYCLES_DEF = LOCK_TIME_US * (CLK_FREQ_KHZ / 1000);
  localparam int OST_TICKS       = 1024;

  // Phase accumulator increments, 24-bit fraction of the 100 MHz clock
  localparam int          ACC_W     = 24;
  localparam logic [23:0] MAIN_INC  = 24'h147ae1; // 8 MHz
  localparam logic [23:0] SLOW_INC  = 24'h001451; // 31 kHz
  localparam logic [23:0] NODE_INC  = 24'h7ae148; // 48 MHz node after the 96 MHz halving
  localparam logic [23:0] TRIM_STEP = 24'h000a3d; // One trim step

  // Register byte offsets
  localparam logic [3:0] OFS_TUNE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_CFG  = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;

  // Field positions
  localparam int TUNE_SRC_BIT   = 7;
  localparam int TUNE_MULTIPLIER_ENABLE_BIT = 6;
  localparam int TRIM_W         = 6;
  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_PRE_LSB    = 3;
  localparam int CFG_CORE_CLOCK_DIVIDER_LSB  = 6;
  localparam int CFG_USBLS_BIT  = 8;
  localparam int CFG_FEAT_LSB   = 9;

  // Reset values
  localparam logic [7:0] TUNE_RST  = 8'h00;
  localparam logic [2:0] FREQ_RST  = 3'h6;
  localparam logic [2:0] PRE_RST   = 3'h0;
  localparam logic [1:0] CORE_CLOCK_DIVIDER_RST = 2'h3;
  localparam logic [3:0] FEAT_RST  = 4'h0;

  typedef enum logic [2:0] {
    crystal_direct_mode, crystal_pll_mode, external_clock_in_mode, external_clock_pll_mode,
    internal_direct_mode, internal_clkout_mode, internal_pll_mode, internal_pll_clkout_mode
  } csp_mode_t;

  typedef enum logic [1:0] {sw_idle, sw_wait_old, sw_wait_new} csp_sw_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } csp_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } csp_wb_rsp_t;

  typedef struct packed {
    logic core_tick;
    logic usb_tick;
    logic slow_osc_enable;
    logic multiplier_running;
  } csp_clk_out_t;

endpackage

// *** rtl/csp_clock_ctrl.sv ***
module csp_clock_ctrl import csp_pkg::*; #(
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire csp_wb_req_t  wb_req,
  output csp_wb_rsp_t       wb_rsp,
  input  wire logic         osc_input_pin,
  input  wire logic         sleep_req,
  output logic              osc_output_pin,
  output logic              osc_output_oe,
  output csp_clk_out_t      clk_out
);

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int OST_W  = $clog2(OST_TICKS + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  localparam logic [OST_W-1:0]  OST_LAST  = OST_W'(OST_TICKS - 1);

  typedef struct packed {
    logic [7:0]        tune;
    logic [2:0]        freq_sel;
    csp_mode_t         mode;
    logic [2:0]        prediv;
    logic [1:0]        core_clock_divider;
    logic              usb_low;
    logic [3:0]        feat;
    logic              ack;
    logic [31:0]       rdata;
    logic [ACC_W-1:0]  main_acc;
    logic [ACC_W-1:0]  slow_acc;
    logic [ACC_W-1:0]  node_acc;
    logic              pin_q;
    logic [1:0]        ext_cnt;
    logic [OST_W-1:0]  ost_cnt;
    logic              osc_ready;
    logic [3:0]        pre_cnt;
    logic              ref_seen;
    logic [LOCK_W-1:0] lock_cnt;
    logic              locked;
    logic [7:0]        post_cnt;
    logic [2:0]        pdiv_cnt;
    logic [2:0]        cpu_cnt;
    logic [1:0]        usb_cnt;
    logic              on_pll;
    csp_sw_t           sw;
    logic              core_tick;
    logic              usb_tick;
  } csp_state_t;

  csp_state_t s;
  csp_state_t next_s;
  logic [1:0] rst_sync;
  logic       rst_n;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Accumulate and report the carry
  function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] a, input logic [ACC_W-1:0] inc);
    acc_step = {1'b0, a} + {1'b0, inc};
  endfunction

  // Prescaler code to ratio minus one
  function automatic logic [3:0] pre_last(input logic [2:0] code);
    case (code)
      3'h0:    pre_last = 4'hb;
      3'h1:    pre_last = 4'h9;
      3'h2:    pre_last = 4'h5;
      3'h3:    pre_last = 4'h4;
      3'h4:    pre_last = 4'h3;
      3'h5:    pre_last = 4'h2;
      3'h6:    pre_last = 4'h1;
      default: pre_last = 4'h0;
    endcase
  endfunction

  // Core divider code to ratio minus one: 11 none, 10 half, 01 third, 00 sixth
  function automatic logic [2:0] cpu_last(input logic [1:0] code);
    case (code)
      2'h3:    cpu_last = 3'h0;
      2'h2:    cpu_last = 3'h1;
      2'h1:    cpu_last = 3'h2;
      default: cpu_last = 3'h5;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Decode of mode and sources

  logic             pll_capable;
  logic             ext_mode;
  logic             xtal_mode;
  logic             int_mode;
  logic             pll_on;
  logic             ext_tick;
  logic [ACC_W-1:0] main_inc;
  logic [ACC_W:0]   main_sum;
  logic [ACC_W:0]   slow_sum;
  logic [ACC_W:0]   node_sum;
  logic             main_tick;
  logic             slow_tick;
  logic             node_tick;
  logic             slow_run;
  logic             prim_tick;
  logic             pre_hit;
  logic [7:0]       post_mask;
  logic             post_hit;
  logic             int_clk_tick;
  logic             pdiv_hit;
  logic             cpu_hit;
  logic             old_tick;
  logic             want_pll;
  logic             cur_tick;
  logic             tgt_tick;
  logic             wb_req_ok;

  // Multiplier-capable modes
  assign pll_capable = (s.mode == crystal_pll_mode) || (s.mode == external_clock_pll_mode) ||
                       (s.mode == internal_pll_mode) || (s.mode == internal_pll_clkout_mode);
  assign ext_mode    = (s.mode == external_clock_in_mode) || (s.mode == external_clock_pll_mode);
  assign xtal_mode   = (s.mode == crystal_direct_mode) || (s.mode == crystal_pll_mode);
  assign int_mode    = !ext_mode && !xtal_mode;

  assign pll_on = s.tune[TUNE_MULTIPLIER_ENABLE_BIT] && pll_capable && !sleep_req;

  // Rising edge of the sampled input clock
  assign ext_tick = osc_input_pin && !s.pin_q;

  assign main_inc = MAIN_INC + ACC_W'({{(ACC_W - TRIM_W){s.tune[TRIM_W-1]}}, s.tune[TRIM_W-1:0]} * TRIM_STEP);

  assign main_sum  = acc_step(s.main_acc, main_inc);
  assign main_tick = main_sum[ACC_W] && !sleep_req;

  assign slow_run  = (int_mode && s.freq_sel == 3'h0 && !s.tune[TUNE_SRC_BIT]) || (|s.feat);
  assign slow_sum  = acc_step(s.slow_acc, SLOW_INC);
  assign slow_tick = slow_sum[ACC_W] && slow_run;

  assign node_sum  = acc_step(s.node_acc, NODE_INC);
  assign node_tick = node_sum[ACC_W] && pll_on && s.locked;

  // main oscillator in internal modes, else the ready input pin, into the multiplier path
  assign prim_tick = int_mode ? main_tick : (ext_tick && s.osc_ready);

  assign pre_hit = prim_tick && (s.pre_cnt == pre_last(s.prediv));

  // divide by 256 or slow oscillator
  assign post_mask = (s.freq_sel == 3'h0) ? 8'hff : (8'hff >> (4'(s.freq_sel) + 4'h1));
  assign post_hit  = main_tick && ((s.post_cnt & post_mask) == post_mask);

  assign int_clk_tick = (s.freq_sel == 3'h0 && !s.tune[TUNE_SRC_BIT]) ? slow_tick : post_hit;

  assign pdiv_hit = prim_tick && (s.pdiv_cnt == cpu_last(s.core_clock_divider));
  assign cpu_hit  = node_tick && (s.cpu_cnt == cpu_last(s.core_clock_divider));

  assign old_tick = (s.mode == internal_direct_mode || s.mode == internal_clkout_mode) ? int_clk_tick : pdiv_hit;
  assign want_pll = pll_on && s.locked;
  assign cur_tick = s.on_pll ? cpu_hit : old_tick;
  assign tgt_tick = s.on_pll ? old_tick : cpu_hit;

  assign wb_req_ok = wb_req.cyc && wb_req.stb && !s.ack;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s           = s;
    next_s.ack       = 1'b0;
    next_s.core_tick = 1'b0;
    next_s.usb_tick  = 1'b0;
    next_s.pin_q     = osc_input_pin;
    next_s.main_acc  = main_sum[ACC_W-1:0];
    next_s.slow_acc  = slow_run ? slow_sum[ACC_W-1:0] : s.slow_acc;
    next_s.node_acc  = (pll_on && s.locked) ? node_sum[ACC_W-1:0] : s.node_acc;

    // Register bus, one-cycle answer
    if (wb_req_ok) begin
      next_s.ack   = 1'b1;
      next_s.rdata = 32'h0000_0000;
      if (wb_req.adr == OFS_TUNE) begin
        next_s.rdata = {24'h00_0000, s.tune};
        if (wb_req.we && wb_req.sel[0]) begin
          next_s.tune = wb_req.dat[7:0];
        end
      end else if (wb_req.adr == OFS_CTRL) begin
        next_s.rdata = {29'h0000_0000, s.freq_sel};
        if (wb_req.we && wb_req.sel[0]) begin
          next_s.freq_sel = wb_req.dat[2:0];
        end
      end else if (wb_req.adr == OFS_CFG) begin
        next_s.rdata = {19'h0_0000, s.feat, s.usb_low, s.core_clock_divider, s.prediv, s.mode};
        if (wb_req.we && wb_req.sel[0]) begin
          next_s.mode   = csp_mode_t'(wb_req.dat[CFG_MODE_LSB +: 3]);
          next_s.prediv = wb_req.dat[CFG_PRE_LSB +: 3];
          next_s.core_clock_divider  = wb_req.dat[CFG_CORE_CLOCK_DIVIDER_LSB +: 2];
        end
        if (wb_req.we && wb_req.sel[1]) begin
          next_s.usb_low = wb_req.dat[CFG_USBLS_BIT];
          next_s.feat    = wb_req.dat[CFG_FEAT_LSB +: 4];
        end
      end else if (wb_req.adr == OFS_STAT) begin
        next_s.rdata = {26'h000_0000, s.ref_seen, slow_run, s.osc_ready, s.on_pll, s.locked, pll_on};
      end
    end

    if (ext_tick) begin
      next_s.ext_cnt = s.ext_cnt + 2'h1;
    end

    // external modes are ready at once
    if (!xtal_mode) begin
      next_s.osc_ready = 1'b1;
      next_s.ost_cnt   = '0;
    end else if (sleep_req) begin
      next_s.osc_ready = 1'b0;
      next_s.ost_cnt   = '0;
    end else if (ext_tick && !s.osc_ready) begin
      next_s.ost_cnt = s.ost_cnt + OST_W'(1);
      if (s.ost_cnt == OST_LAST) begin
        next_s.osc_ready = 1'b1;
      end
    end

    // Prescaler and reference presence
    if (prim_tick) begin
      next_s.pre_cnt = pre_hit ? 4'h0 : (s.pre_cnt + 4'h1);
    end
    if (!pll_on) begin
      next_s.ref_seen = 1'b0;
    end else if (pre_hit) begin
      next_s.ref_seen = 1'b1;
    end

    // lock counter on the system clock
    if (!pll_on) begin
      next_s.lock_cnt = '0;
      next_s.locked   = 1'b0;
    end else if (s.lock_cnt != LOCK_LAST) begin
      next_s.lock_cnt = s.lock_cnt + LOCK_W'(1);
    end else if (s.ref_seen) begin
      next_s.locked = 1'b1;
    end

    // Postscaler and dividers
    if (main_tick) begin
      next_s.post_cnt = s.post_cnt + 8'h01;
    end
    if (prim_tick) begin
      next_s.pdiv_cnt = pdiv_hit ? 3'h0 : (s.pdiv_cnt + 3'h1);
    end
    if (node_tick) begin
      next_s.cpu_cnt = cpu_hit ? 3'h0 : (s.cpu_cnt + 3'h1);
    end

    // wait for old edge then new edge
    case (s.sw)
      sw_idle: begin
        next_s.core_tick = cur_tick;
        if (want_pll != s.on_pll) begin
          next_s.sw = sw_wait_old;
        end
      end
      sw_wait_old: begin
        next_s.core_tick = cur_tick;
        if (want_pll == s.on_pll) begin
          next_s.sw = sw_idle;
        end else if (cur_tick || s.on_pll) begin // A stopped multiplier leaves no edge to wait for
          next_s.sw = sw_wait_new;
        end
      end
      sw_wait_new: begin
        if (want_pll == s.on_pll) begin
          next_s.sw = sw_idle;
        end else if (tgt_tick) begin
          next_s.core_tick = 1'b1;
          next_s.on_pll    = want_pll;
          next_s.sw        = sw_idle;
        end
      end
      default: begin
        next_s.sw = sw_idle;
      end
    endcase
    if (sleep_req) begin
      next_s.core_tick = 1'b0;
    end

    // full speed from the 48 MHz node
    // low speed is a quarter of the core clock
    if (!s.usb_low) begin
      next_s.usb_tick = node_tick;
    end else if (next_s.core_tick) begin
      next_s.usb_cnt  = s.usb_cnt + 2'h1;
      next_s.usb_tick = (s.usb_cnt == 2'h3);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.tune     <= TUNE_RST;
      s.freq_sel <= FREQ_RST;
      s.mode     <= crystal_direct_mode;
      s.prediv   <= PRE_RST;
      s.core_clock_divider    <= CORE_CLOCK_DIVIDER_RST;
      s.feat     <= FEAT_RST;
      s.sw       <= sw_idle;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_rsp.ack   = s.ack;
  assign wb_rsp.dat   = s.rdata;
  assign osc_output_pin = s.ext_cnt[1];
  assign osc_output_oe  = ext_mode;
  assign clk_out.core_tick          = s.core_tick;
  assign clk_out.usb_tick           = s.usb_tick;
  assign clk_out.slow_osc_enable    = slow_run;
  assign clk_out.multiplier_running = pll_on;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pll_mode_gate_a: assert property (!pll_capable |=> !s.locked)
    else $error("multiplier locked in a mode without multiplier");
  pll_enable_bit_a: assert property (!s.tune[TUNE_MULTIPLIER_ENABLE_BIT] |=> !s.locked ##1 !(s.on_pll && s.core_tick))
    else $error("multiplier active with enable bit clear");
  lock_full_count_a: assert property ($rose(s.locked) |-> s.lock_cnt == LOCK_LAST && $past(s.ref_seen))
    else $error("lock flagged before full lock interval");
  no_early_switch_a: assert property ($rose(pll_on) |-> !s.on_pll [*4])
    else $error("core moved to multiplier before lock");
  ext_ready_now_a: assert property (ext_mode ##1 ext_mode |-> s.osc_ready)
    else $error("start-up delay seen in external clock mode");
  ext_div_four_a: assert property (ext_mode && ext_tick && s.ext_cnt == 2'h1 ##1 ext_mode
    |-> osc_output_pin && osc_output_oe)
    else $error("divided output wrong");
  switch_no_runt_a: assert property (s.sw == sw_wait_new && !tgt_tick |=> !s.core_tick)
    else $error("core tick during clock switch");
  slow_osc_on_a: assert property (|s.feat |=> s.slow_acc != $past(s.slow_acc))
    else $error("slow oscillator off while a timer feature needs it");
  usb_low_rate_a: assert property (s.usb_low ##1 s.usb_low && s.usb_tick |-> s.core_tick && s.usb_cnt == 2'h0)
    else $error("low-speed USB tick not a quarter of core ticks");
  bus_answer_a: assert property (wb_req_ok |=> s.ack ##1 !s.ack)
    else $error("bus answer not one cycle");

  switch_done_c: cover property ($rose(s.on_pll));
  crystal_ready_c: cover property ($rose(s.osc_ready));
  usb_low_tick_c: cover property (s.usb_low && s.usb_tick);
  slow_select_c: cover property (int_mode && s.freq_sel == 3'h0 && s.core_tick);

endmodule

// *** verification/csp_ext_osc.sv ***
////////////////////////////////////////////////////////////////////////////////
// External clock source; half period in ns, zero stops it low
module csp_ext_osc (
  input  wire logic [7:0] half_ns,
  output logic            osc
);
  timeunit 1ns;
  timeprecision 100ps;

  // Free-running square wave while a rate is given
  initial begin
    osc = 1'b0;
    forever begin
      if (half_ns == 8'h00) begin
        osc = 1'b0;
        #1;
      end else begin
        #(half_ns);
        osc = ~osc;
      end
    end
  end
endmodule

// *** verification/tb_top.sv ***
////////////////////////////////////////////////////////////////////////////////
module tb_top import csp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LOCK = 50;
  logic         clk;
  logic         arst_n;
  csp_wb_req_t  wb_req;
  csp_wb_rsp_t  wb_rsp;
  logic         osc_input_pin;
  logic         sleep_req;
  logic         osc_output_pin;
  logic         osc_output_oe;
  csp_clk_out_t clk_out;
  logic [7:0]   half_ns = 8'h28;
  logic [31:0]  rd;
  int           mismatches = 0;
  int           n_tests = 0;
  int           n_in = 0;

  // Clock and input edge counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge osc_input_pin) n_in++;

  csp_ext_osc u_osc (.half_ns(half_ns), .osc(osc_input_pin));

  csp_clock_ctrl #(.LOCK_CYCLES(LOCK)) u_dut (
    .clk(clk), .arst_n(arst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .osc_input_pin(osc_input_pin), .sleep_req(sleep_req),
    .osc_output_pin(osc_output_pin), .osc_output_oe(osc_output_oe), .clk_out(clk_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic in_range(input int v, input int lo, input int hi, input string what);
    chk(32'(v >= lo && v <= hi), 32'h1, what);
  endtask

  task automatic give_up(input string what);
    chk(32'h0, 32'h1, what);
    print_verdict();
  endtask

  // Classic single Wishbone cycle, released at the ack edge
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, output logic [31:0] q);
    int i;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wb_rsp.ack !== 1'b1 && i < 20);
    if (wb_rsp.ack !== 1'b1) give_up("no bus ack");
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask

  // Count core and usb ticks over a window
  task automatic count(input int n, output int nc, output int nu);
    nc = 0;
    nu = 0;
    repeat (n) begin
      @(negedge clk);
      if (clk_out.core_tick === 1'b1) nc++;
      if (clk_out.usb_tick === 1'b1) nu++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place, byte enables
  task automatic t_regs();
    wb(0, OFS_TUNE, 4'hf, 0, rd);
    chk(rd, 32'h0, "tune reset");
    wb(0, OFS_CTRL, 4'hf, 0, rd);
    chk(rd, 32'(FREQ_RST), "ctrl reset");
    wb(0, OFS_CFG, 4'hf, 0, rd);
    chk(rd, 32'hc0, "cfg reset");
    wb(1, 4'h2, 4'hf, 32'hffffffff, rd);
    wb(0, 4'h2, 4'hf, 0, rd);
    chk(rd, 32'h0, "unmapped read");
    wb(1, OFS_TUNE, 4'h0, 32'hff, rd);
    wb(0, OFS_TUNE, 4'hf, 0, rd);
    chk(rd, 32'h0, "byte enable low");
    wb(1, OFS_TUNE, 4'hf, 32'ha5, rd);
    wb(0, OFS_TUNE, 4'hf, 0, rd);
    chk(rd, 32'ha5, "tune read back");
    wb(1, OFS_TUNE, 4'hf, 0, rd);
  endtask

  // Enable bit honoured only in multiplier-capable modes
  task automatic t_modes();
    logic [2:0] m;
    wb(1, OFS_TUNE, 4'hf, 32'h40, rd);
    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      wb(1, OFS_CFG, 4'hf, {24'h0, 2'h3, 3'h5, m}, rd);
      @(negedge clk);
      chk(32'(clk_out.multiplier_running), 32'(m == 1 || m == 3 || m == 6 || m == 7), "mult enable");
      chk(32'(osc_output_oe), 32'(m == 2 || m == 3), "clock out enable");
    end
    wb(1, OFS_TUNE, 4'hf, 0, rd);
    @(negedge clk);
    chk(32'(clk_out.multiplier_running), 32'h0, "mult off");
  endtask

  task automatic pin_rise(output int at);
    for (int i = 0; i < 200 && osc_output_pin !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 200 && osc_output_pin !== 1'b1; i++) @(negedge clk);
    if (osc_output_pin !== 1'b1) give_up("clock out stuck");
    at = n_in;
  endtask

  // External input: divide by four out, no start-up wait after sleep
  task automatic t_ext();
    int a;
    int b;
    int nc;
    int nu;
    wb(1, OFS_CFG, 4'hf, 32'hea, rd);
    pin_rise(a);
    pin_rise(b);
    chk(32'(b - a), 32'h4, "clock out divide");
    @(posedge clk);
    sleep_req <= 1'b1;
    repeat (20) @(posedge clk);
    sleep_req <= 1'b0;
    count(40, nc, nu);
    in_range(nc, 1, 10, "ticks after sleep");
  endtask

  // Lock wait, automatic switch, core divider and usb clocks
  task automatic t_pll();
    int i;
    int nc;
    int nu;
    int dv[4];
    dv = '{1, 2, 3, 6};
    wb(1, OFS_CFG, 4'hf, 32'heb, rd);
    wb(1, OFS_TUNE, 4'hf, 32'h40, rd);
    repeat (LOCK - 15) @(posedge clk);
    wb(0, OFS_STAT, 4'hf, 0, rd);
    chk(32'(rd[2:0]), 32'h1, "early switch");
    i = 0;
    do begin
      wb(0, OFS_STAT, 4'hf, 0, rd);
      i++;
    end while (rd[2] !== 1'b1 && i < 40);
    chk(32'(rd[2:0]), 32'h7, "switch after lock");
    for (int k = 0; k < 4; k++) begin
      wb(1, OFS_CFG, 4'h1, {24'h0, 2'(3 - k), 6'h2b}, rd);
      repeat (20) @(posedge clk);
      count(600, nc, nu);
      in_range(nc, 288 / dv[k] - 3, 288 / dv[k] + 3, "core divide");
      in_range(nu, 285, 291, "usb full speed");
    end
    wb(1, OFS_CFG, 4'h3, 32'h1ab, rd);
    repeat (20) @(posedge clk);
    count(600, nc, nu);
    in_range(nc, 141, 147, "core low speed");
    in_range(4 * nu, nc - 4, nc + 4, "usb one per four");
    wb(1, OFS_TUNE, 4'hf, 0, rd);
  endtask

  // Internal oscillator rates and trim
  task automatic t_int();
    int c;
    int hi;
    int lo;
    int nu;
    wb(1, OFS_CFG, 4'h3, 32'hec, rd);
    wb(1, OFS_CTRL, 4'hf, 32'h7, rd);
    repeat (20) @(posedge clk);
    count(1000, c, nu);
    in_range(c, 78, 82, "main direct");
    wb(1, OFS_CTRL, 4'hf, 32'h5, rd);
    count(1000, c, nu);
    in_range(c, 19, 21, "postscaled");
    wb(1, OFS_CTRL, 4'hf, 32'h7, rd);
    wb(1, OFS_TUNE, 4'hf, 32'h1f, rd);
    count(2000, hi, nu);
    wb(1, OFS_TUNE, 4'hf, 32'h20, rd);
    count(2000, lo, nu);
    wb(1, OFS_TUNE, 4'hf, 32'h00, rd);
    count(2000, c, nu);
    in_range(hi, c + 5, c + 15, "trim maximum");
    in_range(lo, c - 15, c - 5, "trim minimum");
    in_range((c - lo) - (hi - c), -3, 3, "trim step even");
  endtask

  // Slow oscillator enables and low-frequency source
  task automatic t_slow();
    @(negedge clk);
    chk(32'(clk_out.slow_osc_enable), 32'h0, "slow idle");
    for (int k = 0; k < 4; k++) begin
      wb(1, OFS_CFG, 4'h2, 32'h1 << (9 + k), rd);
      @(negedge clk);
      chk(32'(clk_out.slow_osc_enable), 32'h1, "slow by feature");
    end
    wb(1, OFS_CFG, 4'h2, 0, rd);
    wb(1, OFS_CTRL, 4'hf, 0, rd);
    @(negedge clk);
    chk(32'(clk_out.slow_osc_enable), 32'h1, "slow selected");
    wb(1, OFS_TUNE, 4'hf, 32'h80, rd);
    @(negedge clk);
    chk(32'(clk_out.slow_osc_enable), 32'h0, "main over 256");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0;
    sleep_req = 1'b0;
    wb_req = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_modes();
    t_ext();
    t_pll();
    t_int();
    t_slow();
    print_verdict();
  end

  // Run limit
  initial begin
    repeat (100000) @(posedge clk);
    give_up("run limit");
  end
endmodule
